// ---- dv/sfe_host.sv ----
// host-side serial controller model: select, link clock and four lines
// assumes the bench calls its tasks; clock is the sequencer's system clock
`timescale 1ns/1ps
module sfe_host (
  input wire logic clock,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in
);
  initial begin
    sclk = 1'h0;
    cs_n = 1'h1;
    io_in = 4'h0;
  end
  // half of the 160 ns link period; link clock stands still between frames
  task automatic half();
    repeat (16) @(posedge clock);
  endtask : half
  // mode 0: lines change while low, device samples on the rise
  task automatic tick(input logic [3:0] v);
    io_in <= v;
    half();
    sclk <= 1'h1;
    half();
    sclk <= 1'h0;
  endtask : tick
  task automatic start();
    @(posedge clock);
    cs_n <= 1'h0;
    half();
  endtask : start
  task automatic byte1(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tick({3'h0, b[i]});
    end
  endtask : byte1
  task automatic quad(input logic [7:0] b);
    tick(b[7:4]);
    tick(b[3:0]);
  endtask : quad
  // select rises only after a further half clock, so the byte boundary is exact
  task automatic stop();
    half();
    cs_n <= 1'h1;
    io_in <= ~io_in;
    repeat (8) @(posedge clock);
  endtask : stop
endmodule : sfe_host

// ---- dv/testbench.sv ----
// self-checking bench of the flash command sequencer
// assumes sfe_host drives the serial pins; array data is a fixed byte
`timescale 1ns/1ps
`include "sfe_defines.svh"
module testbench;
  localparam logic [23:0] SC = 24'h000400;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hf, io_in, io_out, io_oe;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic sclk, cs_n, erase_go, in_progress_flag, write_enable_latch;
  logic [7:0] arr_data = 8'h3c;
  logic [23:0] rd_addr;
  logic [3:0] first_nib, last_nib;
  sfe_pkg::sfe_erase_req_t erase_req, req_seen;
  int error_cnt = 0, check_count = 0, go_n = 0, busy_n = 0, oe_n = 0;
  always #2.5 clock = ~clock;
  sfe_top #(.SECT_CYC(SC), .HALF_CYC(SC), .LARGE_CYC(SC), .DIE_CYC(SC)) uut (.clock, .sys_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sclk, .cs_n,
    .io_in, .io_out, .io_oe, .arr_data, .rd_addr, .erase_go, .erase_req, .in_progress_flag,
    .write_enable_latch);
  sfe_host host (.clock, .sclk, .cs_n, .io_in);
  always @(posedge clock) begin
    if (erase_go === 1'h1) begin
      go_n++;
      req_seen = erase_req;
    end
    if (in_progress_flag === 1'h1) busy_n++;
    if (io_oe === 4'hf) begin
      if (oe_n == 0) first_nib = io_out;
      last_nib = io_out;
      oe_n++;
    end
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  task automatic cmd(input logic [7:0] op, input int nb, input int tail, input logic [23:0] a);
    host.start();
    host.byte1(op);
    for (int i = 0; i < nb; i++) host.byte1(a[23-8*i -: 8]);
    for (int i = 0; i < tail; i++) host.tick(4'h0);
    host.stop();
  endtask : cmd
  task automatic qread(input logic [7:0] op, input logic [7:0] p, input logic [23:0] a,
                       input int nd = 6);
    host.start();
    if (op !== 8'h00) host.byte1(op);
    host.quad(a[23:16]);
    host.quad(a[15:8]);
    host.quad(a[7:0]);
    host.quad(p);
    for (int i = 0; i < nd; i++) host.tick(4'h0);
    host.stop();
  endtask : qread
  task automatic stat(input logic [5:0] e, input string m);
    rd(`SFE_REG_STAT, rdv, rsp);
    chk(rdv[5:0] === e, m);
  endtask : stat
  task automatic erase(input logic [7:0] op, input logic [1:0] k, input logic [23:0] a,
                       input int go);
    cmd(`SFE_OP_WRITE_ENABLE_CMD, 0, 0, 24'h0);
    chk(write_enable_latch === 1'h1, "latch not set");
    go_n = 0;
    busy_n = 0;
    cmd(op, (k == 2'h3) ? 0 : 3, 0, a);
    repeat (int'(SC) + 20) @(posedge clock);
    chk(go_n == go, "erase start");
    if (go == 1) chk(req_seen === {k, (k == 2'h3) ? 24'h0 : a}, "erase target");
    chk(busy_n == go * int'(SC), "busy length");
    chk(write_enable_latch === 1'h0, "latch kept");
    $display("erase test %h done", op);
  endtask : erase
  task automatic t_regs();
    rd(`SFE_REG_CTRL, rdv, rsp);
    chk(rdv === 32'h0, "ctrl reset");
    wr(`SFE_REG_CTRL, 32'h20);
    rd(12'h100, rdv, rsp);
    chk(rsp === `SFE_RESP_ERR, "unmapped read");
    wr(12'h100, 32'h0);
    chk(rsp === `SFE_RESP_ERR, "unmapped write");
    stat(6'h00, "status reset");
    $display("register test done");
  endtask : t_regs
  task automatic t_refuse();
    go_n = 0;
    cmd(`SFE_OP_SECT, 3, 0, 24'h001000);
    cmd(`SFE_OP_WRITE_ENABLE_CMD, 0, 0, 24'h0);
    cmd(`SFE_OP_SECT, 2, 7, 24'h001000);
    chk(go_n == 0, "refused erase ran");
    chk(write_enable_latch === 1'h1, "partial frame cleared latch");
    cmd(`SFE_OP_SECT, 3, 0, 24'h002000);
    oe_n = 0;
    qread(`SFE_OP_QREAD, 8'hff, 24'h000000);
    chk(oe_n == 0 && in_progress_flag === 1'h1, "read during erase");
    repeat (int'(SC)) @(posedge clock);
    $display("refusal test done");
  endtask : t_refuse
  task automatic t_wrap();
    for (int d = 0; d < 4; d++) begin
      cmd(`SFE_OP_WRAP, 1, 0, {6'h0, d[1:0], 16'h0});
      stat({d[1:0], 4'h8}, "wrap depth");
    end
    cmd(`SFE_OP_WRAP, 1, 0, 24'h000000);
    oe_n = 0;
    qread(`SFE_OP_QREAD, 8'hff, 24'h00010e, 7);
    chk(rd_addr === 24'h000108, "wrap address");
    chk(first_nib === 4'h3 && last_nib === 4'hc, "nibble order");
    cmd(`SFE_OP_WRAP, 1, 0, 24'h130000);
    stat(6'h00, "wrap off");
    $display("wrap test done");
  endtask : t_wrap
  task automatic t_enh();
    oe_n = 0;
    qread(`SFE_OP_QREAD, 8'ha5, 24'h000100);
    chk(oe_n > 0, "no quad data");
    stat(6'h04, "enhance entry");
    oe_n = 0;
    qread(8'h00, 8'h5a, 24'h000200);
    chk(oe_n > 0, "enhanced access");
    chk(rd_addr === 24'h000201, "enhanced address");
    stat(6'h04, "enhance kept");
    cmd(`SFE_OP_ENH_RST, 0, 0, 24'h0);
    stat(6'h00, "enhance reset");
    qread(`SFE_OP_QWREAD, 8'hf0, 24'h000300);
    qread(8'h00, 8'haa, 24'h000300);
    stat(6'h00, "enhance cleared");
    $display("enhance test done");
  endtask : t_enh
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    #400us;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clock);
    t_regs();
    t_refuse();
    erase(`SFE_OP_SECT, 2'h0, 24'h012345, 1);
    erase(`SFE_OP_HALF, 2'h1, 24'h028000, 1);
    erase(`SFE_OP_LARGE, 2'h2, 24'h030000, 1);
    erase(`SFE_OP_DIE1, 2'h3, 24'h0, 1);
    erase(`SFE_OP_DIE2, 2'h3, 24'h0, 1);
    wr(`SFE_REG_CTRL, 32'h21);
    erase(`SFE_OP_SECT, 2'h0, 24'hff1000, 0);
    erase(`SFE_OP_DIE2, 2'h3, 24'h0, 0);
    wr(`SFE_REG_LOCK, 32'h2);
    wr(`SFE_REG_CTRL, 32'h30);
    erase(`SFE_OP_LARGE, 2'h2, 24'h120000, 0);
    erase(`SFE_OP_LARGE, 2'h2, 24'h230000, 1);
    rd(`SFE_REG_ECNT, rdv, rsp);
    chk(rdv === 32'h7, "erase count");
    wr(`SFE_REG_CTRL, 32'h20);
    t_wrap();
    t_enh();
    final_report();
  end
endmodule : testbench

// ---- rtl/sfe_defines.svh ----
// constants of the serial flash command sequencer: opcodes, phase lengths, register map
// assumes the includer uses these names only, never the bare figures
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH
`define SFE_OP_QREAD 8'heb
`define SFE_OP_QWREAD 8'he7
`define SFE_OP_ENH_RST 8'hff
`define SFE_OP_WRAP 8'h77
`define SFE_OP_WRITE_ENABLE_CMD 8'h06
`define SFE_OP_SECT 8'h20
`define SFE_OP_LARGE 8'hd8
`define SFE_OP_HALF 8'h52
`define SFE_OP_DIE1 8'h60
`define SFE_OP_DIE2 8'hc7
`define SFE_OPC_LAST 6'h07
`define SFE_OPC_BITS 6'h08
`define SFE_ERA_BITS 6'h20
`define SFE_CNT_MAX 6'h3f
`define SFE_DATA_AT 6'h14
`define SFE_DATA_AT_ENH 6'h0c
`define SFE_QADDR_LAST 5'h05
`define SFE_SADDR_LAST 5'h17
`define SFE_MODE_LAST 5'h01
`define SFE_DUMMY_LAST 5'h03
`define SFE_BYTE_LAST 5'h07
`define SFE_TOGGLE 4'hf
`define SFE_WRAP_MIN 24'h000008
`define SFE_REG_CTRL 12'h000
`define SFE_REG_LOCK 12'h004
`define SFE_REG_STAT 12'h008
`define SFE_REG_ECNT 12'h00c
`define SFE_CTRL_BP 3:0
`define SFE_CTRL_SCHEME 4
`define SFE_CTRL_QE 5
`define SFE_RESP_OK 2'h0
`define SFE_RESP_ERR 2'h2
`define SFE_SECT_CYC 24'h000400
`define SFE_HALF_CYC 24'h000800
`define SFE_LARGE_CYC 24'h001000
`define SFE_DIE_CYC 24'h004000
`endif

// ---- rtl/sfe_erase_timer.sv ----
// self-timed erase cycle counter
// assumes cycles is at least one; start is ignored while busy
`timescale 1ns/1ps
module sfe_erase_timer (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [23:0] cycles,
  output logic busy,
  output logic done
);
  logic [23:0] cnt_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_q <= 24'h000000;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        cnt_q <= cycles;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= 24'h000001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 24'h000001;
        end
      end
    end
  end
endmodule : sfe_erase_timer

// ---- rtl/sfe_pkg.sv ----
// types shared by the serial flash command sequencer
// assumes sfe_defines.svh carries all figures
package sfe_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_MODE = 8'h08,
    ST_DUMMY = 8'h10,
    ST_DATA = 8'h20,
    ST_WRAP = 8'h40,
    ST_SKIP = 8'h80
  } sfe_state_t;
  typedef enum logic [1:0] {
    ERA_SECT = 2'h0,
    ERA_HALF = 2'h1,
    ERA_LARGE = 2'h2,
    ERA_DIE = 2'h3
  } sfe_erase_kind_t;
  typedef struct packed {
    sfe_erase_kind_t kind;
    logic [23:0] addr;
  } sfe_erase_req_t;
endpackage : sfe_pkg

// ---- rtl/sfe_sync.sv ----
// two-stage synchroniser for the serial pins
// assumes inputs are asynchronous to clock
`timescale 1ns/1ps
module sfe_sync #(
  parameter int W = 6
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= '1;
      q <= '1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : sfe_sync

// ---- rtl/sfe_top.sv ----
// serial flash command sequencer: enhance read mode, wrap setup, erase sequences
// assumes serial pins are asynchronous and sclk is slow against clock
// assumes arr_data follows rd_addr within half a serial clock
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sfe_defines.svh"
module sfe_top #(
  parameter logic [23:0] SECT_CYC = `SFE_SECT_CYC,
  parameter logic [23:0] HALF_CYC = `SFE_HALF_CYC,
  parameter logic [23:0] LARGE_CYC = `SFE_LARGE_CYC,
  parameter logic [23:0] DIE_CYC = `SFE_DIE_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic [7:0] arr_data,
  output logic [23:0] rd_addr,
  output logic erase_go,
  output sfe_pkg::sfe_erase_req_t erase_req,
  output logic in_progress_flag,
  output logic write_enable_latch
);
  function automatic logic is_qrd(input logic [7:0] op);
    return (op == `SFE_OP_QREAD) || (op == `SFE_OP_QWREAD);
  endfunction : is_qrd
  function automatic logic is_aera(input logic [7:0] op);
    return (op == `SFE_OP_SECT) || (op == `SFE_OP_LARGE) || (op == `SFE_OP_HALF);
  endfunction : is_aera
  function automatic logic is_die(input logic [7:0] op);
    return (op == `SFE_OP_DIE1) || (op == `SFE_OP_DIE2);
  endfunction : is_die
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : wmerge

  logic [5:0] pin_s;
  logic sclk_p_q, csn_p_q;
  sfe_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d({sclk, cs_n, io_in}),
    .q(pin_s)
  );
  wire sclk_s = pin_s[5];
  wire csn_s = pin_s[4];
  wire [3:0] io_s = pin_s[3:0];
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_p_q <= 1'b1;
      csn_p_q <= 1'b1;
    end else begin
      sclk_p_q <= sclk_s;
      csn_p_q <= csn_s;
    end
  end
  wire rise = sclk_s & ~sclk_p_q & ~csn_s;
  wire fall = ~sclk_s & sclk_p_q & ~csn_s;
  wire cs_fall = ~csn_s & csn_p_q;
  wire cs_rise = csn_s & ~csn_p_q;

  sfe_pkg::sfe_state_t st_q;
  logic [5:0] clk_cnt_q;
  logic [4:0] ph_q;
  logic [7:0] op_sr_q, op_q, mode_q;
  logic [23:0] sh_q, rd_addr_q;
  logic quad_q, enh_q, ent_enh_q, wrap_en_q, hi_q, wel_q, busy, done;
  logic [1:0] wrap_dep_q;
  logic [5:0] ctrl_q;
  logic [15:0] lock_q, ecnt_q;
  logic [3:0] io_out_q, io_oe_q;
  logic erase_go_q;
  sfe_pkg::sfe_erase_req_t erase_req_q;
  wire [7:0] op_nx = {op_sr_q[6:0], io_s[0]};
  wire [7:0] ind_nx = {mode_q[3:0], io_s};
  wire [7:0] byte_nx = {mode_q[6:0], io_s[0]};

  // clock counter over the select-low frame, holding at 63 clocks
  always_ff @(posedge clock) begin
    if (sys_rst || cs_fall) begin
      clk_cnt_q <= 6'h00;
      op_sr_q <= 8'h00;
    end else if (rise) begin
      if (clk_cnt_q != `SFE_CNT_MAX) clk_cnt_q <= clk_cnt_q + 6'h01;
      if (clk_cnt_q <= `SFE_OPC_LAST) op_sr_q <= op_nx;
    end
  end

  // frame sequencer
  always_ff @(posedge clock) begin
    if (sys_rst || cs_rise) begin
      st_q <= sfe_pkg::ST_IDLE;
      ph_q <= 5'h00;
    end else if (cs_fall) begin
      ph_q <= 5'h00;
      if (!enh_q) st_q <= sfe_pkg::ST_CMD;
      else if (busy) st_q <= sfe_pkg::ST_SKIP;
      else st_q <= sfe_pkg::ST_ADDR;
    end else if (rise) begin
      ph_q <= ph_q + 5'h01;
      unique case (st_q)
        sfe_pkg::ST_CMD: begin
          if (clk_cnt_q == `SFE_OPC_LAST) begin
            ph_q <= 5'h00;
            if (busy) st_q <= sfe_pkg::ST_SKIP;
            else if (is_qrd(op_nx) && ctrl_q[`SFE_CTRL_QE]) st_q <= sfe_pkg::ST_ADDR;
            else if (is_aera(op_nx)) st_q <= sfe_pkg::ST_ADDR;
            else if (op_nx == `SFE_OP_WRAP) st_q <= sfe_pkg::ST_WRAP;
            else st_q <= sfe_pkg::ST_SKIP;
          end
        end
        sfe_pkg::ST_ADDR: begin
          if (ph_q == (quad_q ? `SFE_QADDR_LAST : `SFE_SADDR_LAST)) begin
            ph_q <= 5'h00;
            st_q <= quad_q ? sfe_pkg::ST_MODE : sfe_pkg::ST_SKIP;
          end
        end
        sfe_pkg::ST_MODE: begin
          if (ph_q == `SFE_MODE_LAST) begin
            ph_q <= 5'h00;
            st_q <= sfe_pkg::ST_DUMMY;
          end
        end
        sfe_pkg::ST_DUMMY: begin
          if (ph_q == `SFE_DUMMY_LAST) st_q <= sfe_pkg::ST_DATA;
        end
        sfe_pkg::ST_WRAP: begin
          if (ph_q == `SFE_BYTE_LAST) st_q <= sfe_pkg::ST_SKIP;
        end
        sfe_pkg::ST_IDLE, sfe_pkg::ST_DATA, sfe_pkg::ST_SKIP: begin
          ph_q <= 5'h00;
        end
      endcase
    end
  end

  // opcode, address and indicator capture
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      op_q <= 8'h00;
      quad_q <= 1'b0;
      sh_q <= 24'h000000;
      mode_q <= 8'h00;
      ent_enh_q <= 1'b0;
    end else if (cs_fall) begin
      ent_enh_q <= enh_q;
      quad_q <= enh_q;
    end else if (rise) begin
      if (st_q == sfe_pkg::ST_CMD && clk_cnt_q == `SFE_OPC_LAST) begin
        op_q <= op_nx;
        quad_q <= is_qrd(op_nx);
      end
      if (st_q == sfe_pkg::ST_ADDR) sh_q <= quad_q ? {sh_q[19:0], io_s} : {sh_q[22:0], io_s[0]};
      if (st_q == sfe_pkg::ST_MODE) mode_q <= ind_nx;
      if (st_q == sfe_pkg::ST_WRAP) mode_q <= byte_nx;
    end
  end

  // enhance mode: toggling pairs keep it, any equal pair or FFh drops it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      enh_q <= 1'b0;
    end else if (cs_rise && clk_cnt_q == `SFE_OPC_BITS && op_sr_q == `SFE_OP_ENH_RST) begin
      enh_q <= 1'b0;
    end else if (rise && st_q == sfe_pkg::ST_MODE && ph_q == `SFE_MODE_LAST && is_qrd(op_q)) begin
      enh_q <= ((ind_nx[7:4] ^ ind_nx[3:0]) == `SFE_TOGGLE);
    end
  end

  // wrap setup; reset leaves wrap off
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrap_en_q <= 1'b0;
      wrap_dep_q <= 2'h0;
    end else if (rise && st_q == sfe_pkg::ST_WRAP && ph_q == `SFE_BYTE_LAST) begin
      wrap_en_q <= (byte_nx[7:4] == 4'h0);
      if (byte_nx[7:4] == 4'h0) wrap_dep_q <= byte_nx[1:0];
    end
  end

  // data phase: nibble out on each falling edge, high nibble first
  wire [23:0] wmask = (`SFE_WRAP_MIN << wrap_dep_q) - 24'h000001;
  wire [23:0] inc_addr = rd_addr_q + 24'h000001;
  always_ff @(posedge clock) begin
    if (sys_rst || cs_rise) begin
      io_oe_q <= 4'h0;
      io_out_q <= 4'h0;
      hi_q <= 1'b1;
      if (sys_rst) rd_addr_q <= 24'h000000;
    end else if (rise && st_q == sfe_pkg::ST_DUMMY && ph_q == `SFE_DUMMY_LAST) begin
      rd_addr_q <= sh_q;
      hi_q <= 1'b1;
    end else if (fall && st_q == sfe_pkg::ST_DATA) begin
      io_oe_q <= 4'hf;
      io_out_q <= hi_q ? arr_data[7:4] : arr_data[3:0];
      hi_q <= !hi_q;
      // wrap window is at most 64 bytes, so it never leaves the page
      if (!hi_q && wrap_en_q && is_qrd(op_q)) begin
        rd_addr_q <= (rd_addr_q & ~wmask) | (inc_addr & wmask);
      end else if (!hi_q) begin
        rd_addr_q <= inc_addr;
      end
    end
  end

  // erase decision at select rise
  wire prot_lvl = (ctrl_q[`SFE_CTRL_BP] != 4'h0) &&
                  ({8'h00, ~sh_q[23:16]} < (16'h0001 << (ctrl_q[`SFE_CTRL_BP] - 4'h1)));
  wire prot_hit = ctrl_q[`SFE_CTRL_SCHEME] ? lock_q[sh_q[23:20]] : prot_lvl;
  wire prot_any = ctrl_q[`SFE_CTRL_SCHEME] ? (lock_q != 16'h0000) : (ctrl_q[`SFE_CTRL_BP] != 4'h0);
  wire era_a = is_aera(op_q) && clk_cnt_q == `SFE_ERA_BITS;
  wire era_d = is_die(op_q) && clk_cnt_q == `SFE_OPC_BITS;
  wire era_ok = cs_rise && !busy && (era_a || era_d) && !ent_enh_q;
  wire era_blk = era_a ? prot_hit : prot_any;
  wire era_run = era_ok && wel_q && !era_blk;
  logic [23:0] era_cyc;
  sfe_pkg::sfe_erase_kind_t era_kind;
  always_comb begin
    era_kind = sfe_pkg::ERA_DIE;
    era_cyc = DIE_CYC;
    if (op_q == `SFE_OP_SECT) begin
      era_kind = sfe_pkg::ERA_SECT;
      era_cyc = SECT_CYC;
    end else if (op_q == `SFE_OP_HALF) begin
      era_kind = sfe_pkg::ERA_HALF;
      era_cyc = HALF_CYC;
    end else if (op_q == `SFE_OP_LARGE) begin
      era_kind = sfe_pkg::ERA_LARGE;
      era_cyc = LARGE_CYC;
    end
  end
  sfe_erase_timer u_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(era_run),
    .cycles(era_cyc),
    .busy(busy),
    .done(done)
  );
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wel_q <= 1'b0;
      erase_go_q <= 1'b0;
      erase_req_q <= '0;
      ecnt_q <= 16'h0000;
    end else begin
      erase_go_q <= era_run;
      if (cs_rise && !busy && clk_cnt_q == `SFE_OPC_BITS && op_q == `SFE_OP_WRITE_ENABLE_CMD) wel_q <= 1'b1;
      else if (done) wel_q <= 1'b0;
      else if (era_ok && wel_q && era_blk) wel_q <= 1'b0;
      if (era_run) begin
        erase_req_q.kind <= era_kind;
        erase_req_q.addr <= era_d ? 24'h000000 : sh_q;
        ecnt_q <= ecnt_q + 16'h0001;
      end
    end
  end

  // register bus slave
  logic awready_q, wready_q, aw_have_q, w_have_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  wire do_wr = aw_have_q && w_have_q && !bvalid_q;
  wire b_done = bvalid_q && s_axi_bready;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
      aw_have_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end else if (b_done) begin
      aw_have_q <= 1'b0;
      awready_q <= 1'b1;
    end else if (!aw_have_q) begin
      awready_q <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
      w_have_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (b_done) begin
      w_have_q <= 1'b0;
      wready_q <= 1'b1;
    end else if (!w_have_q) begin
      wready_q <= 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= `SFE_RESP_OK;
      ctrl_q <= 6'h00;
      lock_q <= 16'h0000;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= `SFE_RESP_OK;
      if (awaddr_q == `SFE_REG_CTRL) ctrl_q <= 6'(wmerge({26'h0, ctrl_q}, wdata_q, wstrb_q));
      else if (awaddr_q == `SFE_REG_LOCK) lock_q <= 16'(wmerge({16'h0, lock_q}, wdata_q, wstrb_q));
      else if (awaddr_q != `SFE_REG_STAT && awaddr_q != `SFE_REG_ECNT) bresp_q <= `SFE_RESP_ERR;
    end else if (b_done) begin
      bvalid_q <= 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `SFE_RESP_OK;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `SFE_RESP_OK;
      rdata_q <= 32'h00000000;
      unique case (s_axi_araddr)
        `SFE_REG_CTRL: rdata_q <= {26'h0, ctrl_q};
        `SFE_REG_LOCK: rdata_q <= {16'h0, lock_q};
        `SFE_REG_STAT: rdata_q <= {26'h0, wrap_dep_q, wrap_en_q, enh_q, wel_q, busy};
        `SFE_REG_ECNT: rdata_q <= {16'h0, ecnt_q};
        default: rresp_q <= `SFE_RESP_ERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign rd_addr = rd_addr_q;
  assign erase_go = erase_go_q;
  assign erase_req = erase_req_q;
  assign in_progress_flag = busy;
  assign write_enable_latch = wel_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  busy_refuse_a: assert property (rise && st_q == sfe_pkg::ST_CMD && clk_cnt_q == `SFE_OPC_LAST
    && busy |=> st_q == sfe_pkg::ST_SKIP) else $error("command taken while busy");
  enh_src_a: assert property ($rose(enh_q) |-> $past(st_q) == sfe_pkg::ST_MODE)
    else $error("enhance entered outside indicator phase");
  enh_quad_a: assert property ($rose(enh_q) |-> is_qrd(op_q))
    else $error("enhance entered from non-quad read");
  enh_addr_a: assert property (cs_fall && enh_q && !busy |=> st_q == sfe_pkg::ST_ADDR && quad_q)
    else $error("enhanced access did not start at address");
  enh_keep_a: assert property (rise && st_q == sfe_pkg::ST_MODE && ph_q == `SFE_MODE_LAST
    && is_qrd(op_q) && (ind_nx[7:4] ^ ind_nx[3:0]) == `SFE_TOGGLE |=> enh_q)
    else $error("toggling indicator lost enhance");
  enh_drop_a: assert property (rise && st_q == sfe_pkg::ST_MODE && ph_q == `SFE_MODE_LAST
    && (ind_nx[7:4] ^ ind_nx[3:0]) != `SFE_TOGGLE |=> !enh_q)
    else $error("equal indicator pair kept enhance");
  dummy_len_a: assert property ($rose(st_q == sfe_pkg::ST_DATA) |->
    clk_cnt_q == (ent_enh_q ? `SFE_DATA_AT_ENH : `SFE_DATA_AT))
    else $error("data phase at wrong clock");
  enh_reset_a: assert property (cs_rise && clk_cnt_q == `SFE_OPC_BITS
    && op_sr_q == `SFE_OP_ENH_RST |=> !enh_q) else $error("mode reset ignored");
  wrap_set_a: assert property (rise && st_q == sfe_pkg::ST_WRAP && ph_q == `SFE_BYTE_LAST
    |=> wrap_en_q == ($past(byte_nx[7:4]) == 4'h0)) else $error("wrap setting wrong");
  erase_flag_a: assert property (erase_go_q |-> busy && wel_q)
    else $error("erase started without flags");
  erase_end_a: assert property ($fell(busy) && !cs_rise |=> !wel_q)
    else $error("latch held after erase");
  prot_keep_a: assert property (era_ok && wel_q && era_blk |=> !busy && !wel_q && !erase_go_q)
    else $error("protected erase ran");
  no_latch_a: assert property (cs_rise && !wel_q && !busy |=> !busy [*2])
    else $error("erase ran without latch");
  bad_len_a: assert property (cs_rise && is_aera(op_q) && clk_cnt_q != `SFE_ERA_BITS
    |=> !erase_go_q) else $error("partial erase frame ran");
  enh_cov_c: cover property ($rose(enh_q));
  erase_cov_c: cover property (erase_go_q ##1 busy);
  wrap_cov_c: cover property ($rose(wrap_en_q));
  data_cov_c: cover property (st_q == sfe_pkg::ST_DATA && fall && wrap_en_q);
endmodule : sfe_top
